/* src/psr_pkg.sv */
// Constants for the status bit bank: register addresses, bit positions,
// reset values, management frame encodings and frame states.
// Assumes 5-bit register and station addresses on the serial management port.
package psr_pkg;

    localparam int PSR_REG_W = 16;
    localparam int PSR_ADDR_W = 5;

    // Register addresses
    localparam logic [4:0] PSR_ADDR_STATUS = 5'h01;
    localparam logic [4:0] PSR_ADDR_PARTNER = 5'h05;
    localparam logic [4:0] PSR_ADDR_EXTCTRL = 5'h10;
    localparam logic [4:0] PSR_ADDR_QSTAT = 5'h11;
    localparam logic [4:0] PSR_ADDR_TENCTRL = 5'h12;

    // Status register bit positions
    localparam int PSR_BIT_T4 = 15;
    localparam int PSR_BIT_TXFD = 14;
    localparam int PSR_BIT_TXHD = 13;
    localparam int PSR_BIT_TFD = 12;
    localparam int PSR_BIT_THD = 11;
    localparam int PSR_BIT_RSV_HI = 10;
    localparam int PSR_BIT_RSV_LO = 7;
    localparam int PSR_BIT_PRE = 6;
    localparam int PSR_BIT_ANC = 5;
    localparam int PSR_BIT_RF = 4;
    localparam int PSR_BIT_ANA = 3;
    localparam int PSR_BIT_LINK = 2;
    localparam int PSR_BIT_JAB = 1;
    localparam int PSR_BIT_EXT = 0;

    // Bits in the other registers
    localparam int PSR_BIT_LPRF = 13;
    localparam int PSR_BIT_OVR = 15;
    localparam int PSR_BIT_QJAB = 2;
    localparam int PSR_BIT_QRF = 1;
    localparam int PSR_BIT_QLINK = 0;
    localparam int PSR_BIT_JABEN = 5;

    // Reset values
    localparam logic PSR_RST_T4 = 1'h0;
    localparam logic PSR_RST_TXFD = 1'h1;
    localparam logic PSR_RST_TXHD = 1'h1;
    localparam logic PSR_RST_TFD = 1'h1;
    localparam logic PSR_RST_THD = 1'h1;
    localparam logic [3:0] PSR_RST_RSV = 4'h0;
    localparam logic PSR_RST_PRE = 1'h0;
    localparam logic PSR_RST_ANA = 1'h1;
    localparam logic PSR_RST_EXT = 1'h1;
    localparam logic PSR_RST_LATCH = 1'h0;
    localparam logic PSR_RST_OVR = 1'h0;
    localparam logic PSR_RST_JABEN = 1'h1;

    // Management frame encodings and lengths
    localparam logic [1:0] PSR_OP_READ = 2'h2;
    localparam logic [1:0] PSR_OP_WRITE = 2'h1;
    localparam logic [5:0] PSR_PREAMBLE_LEN = 6'h20;
    localparam logic [3:0] PSR_HDR_LAST = 4'hB;
    localparam logic [3:0] PSR_TA_LAST = 4'h1;
    localparam logic [3:0] PSR_DATA_LAST = 4'hF;

    typedef enum logic [5:0] {
        PSR_ST_PRE = 6'h01,
        PSR_ST_START = 6'h02,
        PSR_ST_HDR = 6'h04,
        PSR_ST_TA = 6'h08,
        PSR_ST_RD = 6'h10,
        PSR_ST_WR = 6'h20
    } psr_frame_t;

endpackage

/* src/psr_sync2.sv */
// Two flip-flop synchroniser for pin levels.
// Assumes the inputs change slowly against the sampling clock.
`timescale 1ns/1ns
module psr_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    // Refused at elaboration, before any logic is built
    if (WIDTH < 1)
    begin : g_badWidth
        $error("psr_sync2: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            stage1_r <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1_r <= asyncIn;
            syncOut <= stage1_r;
        end
    end
endmodule // psr_sync2

/* src/psr_status_bank.sv */
// Status bit bank of a twisted-pair PHY with its serial management slave.
// Assumes mdc and mdio arrive from pins; the condition inputs come from
// link monitor, negotiation and jabber logic running on clk_sys.
`timescale 1ns/1ns
module psr_status_bank
    import psr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mdcPin,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe_n,
    input wire logic [psr_pkg::PSR_ADDR_W-1:0] phyAddr,
    input wire logic anEnable,
    input wire logic anComplete,
    input wire logic lcwReceived,
    input wire logic lcwRemoteFault,
    input wire logic linkValid,
    input wire logic jabberSeen,
    output logic cap10Full,
    output logic cap10Half,
    output logic preambleSuppress,
    output logic overrideEn,
    output logic jabberCheckEn
);
    import psr_pkg::*;

    logic [1:0] pinSync;
    logic mdcS, mdioS, mdcPrev_r, mdcRise;

    psr_frame_t state_r, state_nxt;
    logic [5:0] preCnt_r;
    logic [3:0] bitCnt_r;
    logic [11:0] hdr_r, hdrNext;
    logic [15:0] wrShift_r, wrWord, rdShift_r, readWord;
    logic [4:0] regSel_r;
    logic own_r, isRead_r, preReady, hdrDone, opValid, addrHit, rdStart, wrDone, rdClr;

    logic tfd_r, thd_r, preSup_r, ovr_r, jabEn_r;
    logic anLatch_r, rfLatch_r, lpRf_r, linkLatch_r, jabLatch_r, anCond, rfSet;

    // Both pins pass the same two stages, so their relative timing holds
    psr_sync2 #(
        .WIDTH(2)
    ) u_pinSync (
        .clk_sys(clk_sys),
        .reset(reset),
        .asyncIn({mdcPin, mdioIn}),
        .syncOut(pinSync)
    );

    assign mdcS = pinSync[1];
    assign mdioS = pinSync[0];
    assign mdcRise = mdcS & ~mdcPrev_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            mdcPrev_r <= 1'h0;
        else
            mdcPrev_r <= mdcS;
    end

    // Frame decode
    assign hdrNext = {hdr_r[10:0], mdioS};
    assign wrWord = {wrShift_r[14:0], mdioS};
    assign preReady = (preCnt_r >= PSR_PREAMBLE_LEN) | preSup_r;
    assign hdrDone = (state_r == PSR_ST_HDR) & mdcRise & (bitCnt_r == PSR_HDR_LAST);
    assign opValid = (hdrNext[11:10] == PSR_OP_READ) | (hdrNext[11:10] == PSR_OP_WRITE);
    assign addrHit = hdrNext[9:5] == phyAddr;
    assign rdStart = hdrDone & addrHit & (hdrNext[11:10] == PSR_OP_READ);
    assign wrDone = (state_r == PSR_ST_WR) & mdcRise & (bitCnt_r == PSR_DATA_LAST)
        & own_r;

    // A read of either view releases the shared latches
    assign rdClr = rdStart & ((hdrNext[4:0] == PSR_ADDR_STATUS)
        | (hdrNext[4:0] == PSR_ADDR_QSTAT));

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            PSR_ST_PRE:
                if (mdcRise & ~mdioS & preReady)
                    state_nxt = PSR_ST_START;
            PSR_ST_START:
                if (mdcRise)
                    state_nxt = mdioS ? PSR_ST_HDR : PSR_ST_PRE;
            PSR_ST_HDR:
                if (hdrDone)
                    state_nxt = opValid ? PSR_ST_TA : PSR_ST_PRE;
            PSR_ST_TA:
                if (mdcRise & (bitCnt_r == PSR_TA_LAST))
                    state_nxt = isRead_r ? PSR_ST_RD : PSR_ST_WR;
            PSR_ST_RD, PSR_ST_WR:
                if (mdcRise & (bitCnt_r == PSR_DATA_LAST))
                    state_nxt = PSR_ST_PRE;
            default:
                state_nxt = PSR_ST_PRE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state_r <= PSR_ST_PRE;
        else
            state_r <= state_nxt;
    end

    // Bit counter restarts on every state change
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            bitCnt_r <= 4'h0;
        else if (state_nxt != state_r)
            bitCnt_r <= 4'h0;
        else if (mdcRise)
            bitCnt_r <= bitCnt_r + 4'h1;
    end

    // Preamble ones, saturating; a frame end needs a fresh preamble unless preSup_r is set
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            preCnt_r <= 6'h00;
        else if (state_r != PSR_ST_PRE)
            preCnt_r <= 6'h00;
        else if (mdcRise)
        begin
            if (!mdioS)
                preCnt_r <= 6'h00;
            else if (preCnt_r < PSR_PREAMBLE_LEN)
                preCnt_r <= preCnt_r + 6'h01;
        end
    end

    // Header and write data shift registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            hdr_r <= 12'h000;
            wrShift_r <= 16'h0000;
            regSel_r <= 5'h00;
            own_r <= 1'h0;
            isRead_r <= 1'h0;
        end
        else
        begin
            if ((state_r == PSR_ST_HDR) & mdcRise)
            begin
                hdr_r <= hdrNext;
            end
            if (hdrDone)
            begin
                regSel_r <= hdrNext[4:0];
                own_r <= addrHit;
                isRead_r <= hdrNext[11:10] == PSR_OP_READ;
            end
            if ((state_r == PSR_ST_WR) & mdcRise)
            begin
                wrShift_r <= wrWord;
            end
        end
    end

    // Read data mux over the live latch values
    always_comb
    begin
        readWord = 16'h0000;
        case (hdrNext[4:0])
            PSR_ADDR_STATUS:
            begin
                readWord[PSR_BIT_T4] = PSR_RST_T4;
                readWord[PSR_BIT_TXFD] = PSR_RST_TXFD;
                readWord[PSR_BIT_TXHD] = PSR_RST_TXHD;
                readWord[PSR_BIT_TFD] = tfd_r;
                readWord[PSR_BIT_THD] = thd_r;
                readWord[PSR_BIT_RSV_HI:PSR_BIT_RSV_LO] = PSR_RST_RSV;
                readWord[PSR_BIT_PRE] = preSup_r;
                readWord[PSR_BIT_ANC] = anLatch_r;
                readWord[PSR_BIT_RF] = rfLatch_r;
                readWord[PSR_BIT_ANA] = PSR_RST_ANA;
                readWord[PSR_BIT_LINK] = linkLatch_r;
                readWord[PSR_BIT_JAB] = jabLatch_r;
                readWord[PSR_BIT_EXT] = PSR_RST_EXT;
            end
            PSR_ADDR_PARTNER:
                readWord[PSR_BIT_LPRF] = lpRf_r;
            PSR_ADDR_EXTCTRL:
                readWord[PSR_BIT_OVR] = ovr_r;
            PSR_ADDR_QSTAT:
            begin
                readWord[PSR_BIT_QJAB] = jabLatch_r;
                readWord[PSR_BIT_QRF] = rfLatch_r;
                readWord[PSR_BIT_QLINK] = linkLatch_r;
            end
            PSR_ADDR_TENCTRL:
                readWord[PSR_BIT_JABEN] = jabEn_r;
            default:
                readWord = 16'h0000;
        endcase
    end

    // Pin drive: released in the first turnaround bit, zero in the second,
    // then sixteen data bits, each changed just after a rising mdc
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rdShift_r <= 16'h0000;
            mdioOut <= 1'h0;
            mdioOe_n <= 1'h1;
        end
        else
        begin
            if (rdStart)
            begin
                rdShift_r <= readWord;
            end
            else if (mdcRise & own_r & isRead_r)
            begin
                if ((state_r == PSR_ST_TA) & (bitCnt_r != PSR_TA_LAST))
                begin
                    mdioOut <= 1'h0;
                    mdioOe_n <= 1'h0;
                end
                else if ((state_r == PSR_ST_TA)
                    | ((state_r == PSR_ST_RD) & (bitCnt_r != PSR_DATA_LAST)))
                begin
                    mdioOut <= rdShift_r[15];
                    mdioOe_n <= 1'h0;
                    rdShift_r <= {rdShift_r[14:0], 1'h0};
                end
                else if (state_r == PSR_ST_RD)
                begin
                    mdioOut <= 1'h0;
                    mdioOe_n <= 1'h1;
                end
            end
        end
    end

    // Control bits written by the manager
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tfd_r <= PSR_RST_TFD;
            thd_r <= PSR_RST_THD;
            preSup_r <= PSR_RST_PRE;
            ovr_r <= PSR_RST_OVR;
            jabEn_r <= PSR_RST_JABEN;
        end
        else if (wrDone)
        begin
            // Reserved bits carry no state here, so they always read zero
            if ((regSel_r == PSR_ADDR_STATUS) & ovr_r)
            begin
                tfd_r <= wrWord[PSR_BIT_TFD];
                thd_r <= wrWord[PSR_BIT_THD];
                preSup_r <= wrWord[PSR_BIT_PRE];
            end
            if (regSel_r == PSR_ADDR_EXTCTRL)
            begin
                ovr_r <= wrWord[PSR_BIT_OVR];
            end
            if (regSel_r == PSR_ADDR_TENCTRL)
            begin
                jabEn_r <= wrWord[PSR_BIT_JABEN];
            end
        end
    end

    // Latches: the live condition is folded into the clear, so a set
    // in the read cycle survives; a read releases all but lpRf_r, as does anEnable low for the an latch and jabEn_r low for the jabber latch
    assign anCond = anEnable & anComplete;
    assign rfSet = lcwReceived & lcwRemoteFault;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            anLatch_r <= PSR_RST_LATCH;
        else if (!anEnable)
            anLatch_r <= 1'h0;
        else if (rdClr)
            anLatch_r <= anCond;
        else
            anLatch_r <= anLatch_r | anCond;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rfLatch_r <= PSR_RST_LATCH;
            lpRf_r <= PSR_RST_LATCH;
        end
        else
        begin
            if (rdClr)
                rfLatch_r <= rfSet;
            else
                rfLatch_r <= rfLatch_r | rfSet;
            if (lcwReceived)
                lpRf_r <= lcwRemoteFault;
        end
    end

    // Resets low so a link that never came up is not reported valid
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            linkLatch_r <= PSR_RST_LATCH;
        else if (rdClr)
            linkLatch_r <= linkValid;
        else
            linkLatch_r <= linkLatch_r & linkValid;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            jabLatch_r <= PSR_RST_LATCH;
        else if (!jabEn_r)
            jabLatch_r <= 1'h0;
        else if (rdClr)
            jabLatch_r <= jabberSeen;
        else
            jabLatch_r <= jabLatch_r | jabberSeen;
    end

    assign cap10Full = tfd_r;
    assign cap10Half = thd_r;
    assign preambleSuppress = preSup_r;
    assign overrideEn = ovr_r;
    assign jabberCheckEn = jabEn_r;

endmodule // psr_status_bank

/* sim/psr_status_chk.sv */
// Checker for the status bank: management line timing and config outputs.
// Assumes an mdc pin period of at least 16 clk_sys cycles.
`timescale 1ns/1ns
module psr_status_chk
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mdcPin,
    input wire logic mdioOut,
    input wire logic mdioOe_n,
    input wire logic cap10Full,
    input wire logic cap10Half,
    input wire logic preambleSuppress,
    input wire logic overrideEn,
    input wire logic jabberCheckEn
);
    logic mdcD_r;
    logic [3:0] sinceRise_r;
    logic [4:0] drvRises_r;
    logic mdcRise;
    logic [4:0] cfg;
    assign mdcRise = mdcPin && !mdcD_r;
    assign cfg = {cap10Full, cap10Half, preambleSuppress, overrideEn, jabberCheckEn};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    always_ff @(posedge clk_sys)
        mdcD_r <= mdcPin;
    // Saturates so a change long after any mdc rise still fails
    always_ff @(posedge clk_sys)
        if (reset)
            sinceRise_r <= 4'hF;
        else if (mdcRise)
            sinceRise_r <= 4'h0;
        else if (sinceRise_r != 4'hF)
            sinceRise_r <= sinceRise_r + 4'h1;
    always_ff @(posedge clk_sys)
        if (reset || mdioOe_n)
            drvRises_r <= 5'h00;
        else if (mdcRise)
            drvRises_r <= drvRises_r + 5'h01;
    AST_RESET_CFG:
        assert property (disable iff (1'b0) reset |=> cfg == 5'h19) else $error("Bad config reset");
    AST_RESET_LINE:
        assert property (disable iff (1'b0) reset |=> mdioOe_n && !mdioOut) else $error("Line driven");
    AST_CW_LOCK:
        assert property (!overrideEn |=> $stable(cfg[4:2])) else $error("Locked bit changed");
    AST_CFG_AT_RISE:
        assert property ($changed(cfg) |-> mdioOe_n && sinceRise_r inside {[1:8]})
        else $error("Config change off frame timing");
    AST_TA_ZERO:
        assert property ($fell(mdioOe_n) |-> !mdioOut) else $error("Turnaround bit not zero");
    AST_DRIVE_LEN:
        assert property ($rose(mdioOe_n) |-> drvRises_r == 5'h11) else $error("Bad drive length");
    AST_OUT_AT_RISE:
        assert property ($changed({mdioOut, mdioOe_n}) |-> sinceRise_r inside {[1:8]})
        else $error("Line change off mdc rise");
    AST_BIT_STANDS:
        assert property ($changed(mdioOut) && !mdioOe_n |=> $stable(mdioOut) [*8])
        else $error("Driven bit too short");
endmodule // psr_status_chk

bind psr_status_bank psr_status_chk i_chk (.clk_sys(clk_sys), .reset(reset), .mdcPin(mdcPin),
    .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .cap10Full(cap10Full), .cap10Half(cap10Half),
    .preambleSuppress(preambleSuppress), .overrideEn(overrideEn), .jabberCheckEn(jabberCheckEn));

/* sim/psr_sta_model.sv */
// Station management model: frame master on mdc and the data line.
// Assumes a pull-up on the shared line; mdc stands low between frames.
`timescale 1ns/1ns
module psr_sta_model
(
    input wire logic clk_sys,
    input wire logic mdioOut,
    input wire logic mdioOe_n,
    output logic mdcPin,
    output logic mdioIn,
    output logic [15:0] rdData,
    output logic rdValid
);
    import psr_pkg::*;
    logic drvEn = 1'b1;
    logic drvVal = 1'b1;
    // Pull-up wins when nobody drives
    assign mdioIn = (mdioOe_n === 1'b0) ? mdioOut : (drvEn ? drvVal : 1'b1);
    initial
    begin
        mdcPin = 1'b0;
        rdData = 16'h0000;
        rdValid = 1'b0;
    end
    task automatic clockBit(input logic v, input logic en, output logic s);
        @(posedge clk_sys);
        mdcPin <= 1'b0;
        drvEn <= en;
        drvVal <= v;
        repeat (8) @(posedge clk_sys);
        s = mdioIn;
        mdcPin <= 1'b1;
        repeat (7) @(posedge clk_sys);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, input int pre);
        logic [31:0] w;
        logic [15:0] r;
        logic s;
        logic isRd;
        isRd = (op == PSR_OP_READ);
        w = {2'h1, op, pa, ra, 2'h2, (ra == PSR_ADDR_STATUS) ? (wd & 16'hF87F) : wd};
        repeat (pre) clockBit(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--)
        begin
            clockBit(w[i], !(isRd && i < 18), s);
            if (i < 16)
                r[i] = s;
        end
        @(posedge clk_sys);
        mdcPin <= 1'b0;
        drvEn <= 1'b1;
        drvVal <= 1'b1;
        if (isRd)
        begin
            rdData <= r;
            rdValid <= 1'b1;
            @(posedge clk_sys);
            rdValid <= 1'b0;
        end
    endtask
endmodule // psr_sta_model

/* sim/phy_status_register_bits_test.sv */
// Self-checking bench for the status bit bank behind its management port.
// Assumes the station model as frame master and a 250 MHz clk_sys.
`timescale 1ns/1ns
module phy_status_register_bits_test;
    import psr_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [4:0] phyAddr = 5'h00;
    logic [4:0] tgtAddr;
    logic anEnable = 1'b0;
    logic anComplete = 1'b0;
    logic lcwReceived = 1'b0;
    logic lcwRemoteFault = 1'b0;
    logic linkValid = 1'b1;
    logic jabberSeen = 1'b0;
    logic mdcPin, mdioIn, mdioOut, mdioOe_n, rdValid;
    logic cap10Full, cap10Half, preambleSuppress, overrideEn, jabberCheckEn;
    logic [15:0] rdData, d, e;
    logic [15:0] expQ[$];
    int errorCnt = 0;
    int testsRun = 0;
    int cycles = 0;
    always #2 clk_sys = ~clk_sys;
    psr_status_bank i_dut (.clk_sys(clk_sys), .reset(reset), .mdcPin(mdcPin), .mdioIn(mdioIn),
        .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .phyAddr(phyAddr), .anEnable(anEnable),
        .anComplete(anComplete), .lcwReceived(lcwReceived), .lcwRemoteFault(lcwRemoteFault),
        .linkValid(linkValid), .jabberSeen(jabberSeen), .cap10Full(cap10Full),
        .cap10Half(cap10Half), .preambleSuppress(preambleSuppress), .overrideEn(overrideEn),
        .jabberCheckEn(jabberCheckEn));
    psr_sta_model i_sta (.clk_sys(clk_sys), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n),
        .mdcPin(mdcPin), .mdioIn(mdioIn), .rdData(rdData), .rdValid(rdValid));
    task automatic finalReport();
        // A read whose answer never came counts as a mismatch
        if (expQ.size() != 0)
            errorCnt++;
        $display("Comparisons %0d, mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmpWord(input logic [15:0] x, input logic [15:0] got);
        testsRun++;
        if (got !== x)
        begin
            errorCnt++;
            $display("CHECK FAILED at %0t: expected %h, got %h", $time, x, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] x, input int pre = 32);
        expQ.push_back(x);
        i_sta.frame(PSR_OP_READ, tgtAddr, ra, 16'h0000, pre);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] x);
        i_sta.frame(PSR_OP_WRITE, tgtAddr, ra, x, 32);
        tick(2);
    endtask
    task automatic cfgIs(input logic [15:0] x);
        cmpWord(x, {11'h000, cap10Full, cap10Half, preambleSuppress, overrideEn, jabberCheckEn});
    endtask
    task automatic lcw(input logic f);
        lcwRemoteFault <= f;
        lcwReceived <= 1'b1;
        tick(1);
        lcwReceived <= 1'b0;
    endtask
    task automatic jab();
        jabberSeen <= 1'b1;
        tick(2);
        jabberSeen <= 1'b0;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (rdValid === 1'b1)
        begin
            e = expQ.pop_front();
            cmpWord(e, rdData);
        end
        // Ceiling well above the roughly 36k cycles the frames need
        if (cycles == 80000)
        begin
            errorCnt++;
            finalReport();
        end
    end
    initial
    begin
        d = 16'($urandom(32'h44EC8059));
        tick(1);
        phyAddr <= d[4:0];
        tgtAddr = d[4:0];
        tick(4);
        reset <= 1'b0;
        tick(3);
        rd(5'h01, 16'h7809);
        rd(5'h01, 16'h780D);
        cfgIs(16'h0019);
        rd(5'h10, 16'h0000);
        rd(5'h12, 16'h0020);
        rd(5'h11, 16'h0001);
        wr(5'h01, 16'h0000);
        rd(5'h01, 16'h780D);
        wr(5'h10, 16'h8000);
        wr(5'h01, 16'h0040);
        cfgIs(16'h0007);
        rd(5'h01, 16'h604D, 0);
        for (int i = 0; i < 3; i++)
        begin
            d = 16'($urandom);
            wr(5'h01, d);
            rd(5'h01, {3'h3, d[12:11], 4'h0, d[6], 6'h0D});
        end
        wr(5'h01, 16'h1800);
        cfgIs(16'h001B);
        // Suppression off: a frame without preamble is ignored, line floats high
        rd(5'h01, 16'hFFFF, 0);
        lcw(1'b1);
        rd(5'h05, 16'h2000);
        rd(5'h01, 16'h781D);
        rd(5'h11, 16'h0001);
        lcw(1'b1);
        rd(5'h11, 16'h0003);
        rd(5'h01, 16'h780D);
        lcw(1'b0);
        rd(5'h05, 16'h0000);
        jab();
        rd(5'h11, 16'h0005);
        rd(5'h01, 16'h780D);
        anComplete <= 1'b1;
        tick(2);
        rd(5'h01, 16'h780D);
        anEnable <= 1'b1;
        tick(2);
        anComplete <= 1'b0;
        tick(2);
        rd(5'h01, 16'h782D);
        rd(5'h01, 16'h780D);
        anEnable <= 1'b0;
        linkValid <= 1'b0;
        tick(2);
        linkValid <= 1'b1;
        rd(5'h11, 16'h0000);
        rd(5'h01, 16'h780D);
        wr(5'h12, 16'h0000);
        cfgIs(16'h001A);
        jab();
        rd(5'h11, 16'h0001);
        wr(5'h12, 16'h0020);
        tgtAddr = tgtAddr ^ 5'h01;
        rd(5'h01, 16'hFFFF);
        tgtAddr = tgtAddr ^ 5'h01;
        rd(5'h1F, 16'h0000);
        tick(4);
        finalReport();
    end
endmodule // phy_status_register_bits_test
